// ===== src/dbg_window_pkg.sv
// Shared constants and carrier types for the debug register-file window
package dbg_window_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ENTRY_COUNT = 4;
  localparam int IDX_W = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_WORD_EIGHT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_WORD_NINE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_WORD_TEN = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_WORD_ELEVEN = 8'h2c;

  // ----------------------------------------------------------------
  // Reset values and entry indices
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_EIGHT = 2'h0;
  localparam logic [IDX_W-1:0] IDX_NINE = 2'h1;
  localparam logic [IDX_W-1:0] IDX_TEN = 2'h2;
  localparam logic [IDX_W-1:0] IDX_ELEVEN = 2'h3;
  localparam logic [IDX_W-1:0] PULSE_ENTRY_DEFAULT = 2'h3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dbg_req_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } core_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] eleven;
    logic [DATA_W-1:0] ten;
    logic [DATA_W-1:0] nine;
    logic [DATA_W-1:0] eight;
  } regfile_view_t;

endpackage

// ===== src/core_debug_regfile_window.sv
// Debug window onto core register-file words eight to eleven
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Debug accesses inspect and modify halted core state
// - Read returns full 32-bit register contents
// - Debug access equals core instruction access, effects included
// - Writes to output pin register fire pulse
// - Entries eight to eleven at 20h..2Ch
// - Each entry 32-bit read/write, zero after reset
module core_debug_regfile_window #(
  parameter logic [dbg_window_pkg::IDX_W-1:0] PULSE_ENTRY =
    dbg_window_pkg::PULSE_ENTRY_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire dbg_window_pkg::dbg_req_t dbg_req_in,
  input wire dbg_window_pkg::core_wr_t core_wr_in,
  output logic [dbg_window_pkg::DATA_W-1:0] rdata_out,
  output dbg_window_pkg::regfile_view_t regfile_out,
  output logic [dbg_window_pkg::DATA_W-1:0] output_pin_register_out,
  output logic pulse_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;
  logic next_rst_meta_n;
  logic next_rst_n;

  // Two stages so a release near the edge never reaches the logic half-set
  always_comb begin
    next_rst_meta_n = 1'b1;
    next_rst_n = rst_meta_n;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= next_rst_meta_n;
      rst_n <= next_rst_n;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit;
  logic [dbg_window_pkg::IDX_W-1:0] hit_idx;

  always_comb begin
    hit = 1'b1;
    hit_idx = dbg_window_pkg::IDX_EIGHT;
    if (dbg_req_in.addr == dbg_window_pkg::OFS_WORD_EIGHT) begin
      hit_idx = dbg_window_pkg::IDX_EIGHT;
    end else if (dbg_req_in.addr == dbg_window_pkg::OFS_WORD_NINE) begin
      hit_idx = dbg_window_pkg::IDX_NINE;
    end else if (dbg_req_in.addr == dbg_window_pkg::OFS_WORD_TEN) begin
      hit_idx = dbg_window_pkg::IDX_TEN;
    end else if (dbg_req_in.addr == dbg_window_pkg::OFS_WORD_ELEVEN) begin
      hit_idx = dbg_window_pkg::IDX_ELEVEN;
    end else begin
      hit = 1'b0;
    end
  end

  logic dbg_wr_hit;
  logic dbg_rd_hit;
  assign dbg_wr_hit = dbg_req_in.wr && hit;
  assign dbg_rd_hit = dbg_req_in.rd && hit;

  // ----------------------------------------------------------------
  // Register file words, read data and pulse
  // ----------------------------------------------------------------
  logic [dbg_window_pkg::DATA_W-1:0] words [dbg_window_pkg::ENTRY_COUNT];
  logic [dbg_window_pkg::DATA_W-1:0]
    next_words [dbg_window_pkg::ENTRY_COUNT];
  logic [dbg_window_pkg::DATA_W-1:0] next_rdata;
  logic next_pulse;

  // Debug write wins a same-cycle clash; the core should be halted anyway
  always_comb begin
    next_words = words;
    next_pulse = 1'b0;
    if (dbg_wr_hit) begin
      next_words[hit_idx] = dbg_req_in.wdata;
      next_pulse = (hit_idx == PULSE_ENTRY);
    end else if (core_wr_in.en) begin
      next_words[core_wr_in.idx] = core_wr_in.data;
      next_pulse = (core_wr_in.idx == PULSE_ENTRY);
    end
  end

  // Read data live for one cycle only; unmapped reads return zero
  always_comb begin
    next_rdata = dbg_window_pkg::READ_IDLE;
    if (dbg_rd_hit) begin
      next_rdata = words[hit_idx];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dbg_window_pkg::ENTRY_COUNT; i++) begin
        words[i] <= dbg_window_pkg::WORD_RESET;
      end
      rdata_out <= dbg_window_pkg::READ_IDLE;
      pulse_out <= 1'b0;
    end else begin
      words <= next_words;
      rdata_out <= next_rdata;
      pulse_out <= next_pulse;
    end
  end

  assign regfile_out.eight = words[dbg_window_pkg::IDX_EIGHT];
  assign regfile_out.nine = words[dbg_window_pkg::IDX_NINE];
  assign regfile_out.ten = words[dbg_window_pkg::IDX_TEN];
  assign regfile_out.eleven = words[dbg_window_pkg::IDX_ELEVEN];
  assign output_pin_register_out = words[PULSE_ENTRY];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in || !rst_n);

  sequence s_dbg_pin_write;
    dbg_wr_hit && (hit_idx == PULSE_ENTRY);
  endsequence

  sequence s_pulse_then_pin;
    pulse_out && (output_pin_register_out == $past(dbg_req_in.wdata));
  endsequence

  a_read_returns_word: assert property (
    dbg_rd_hit |=> rdata_out == $past(words[hit_idx]))
    else $error("read data differs from register word");

  a_read_idle_zero: assert property (
    !$past(dbg_rd_hit) |-> rdata_out == dbg_window_pkg::READ_IDLE)
    else $error("read data not zero outside read answer");

  a_write_stores: assert property (
    dbg_wr_hit |=> words[$past(hit_idx)] == $past(dbg_req_in.wdata))
    else $error("debug write not stored at decoded entry");

  a_unmapped_no_effect: assert property (
    dbg_req_in.wr && !hit && !core_wr_in.en |=>
      regfile_out == $past(regfile_out) && !pulse_out)
    else $error("unmapped write changed state");

  a_pin_write_pulse: assert property (
    s_dbg_pin_write |=> s_pulse_then_pin)
    else $error("pin register write gave no pulse");

  a_pulse_has_cause: assert property (
    pulse_out |-> $past((dbg_wr_hit && hit_idx == PULSE_ENTRY) ||
      (!dbg_wr_hit && core_wr_in.en && core_wr_in.idx == PULSE_ENTRY)))
    else $error("pulse without a pin register write");

  a_core_write_same: assert property (
    core_wr_in.en && !dbg_wr_hit |=>
      words[$past(core_wr_in.idx)] == $past(core_wr_in.data))
    else $error("core write not stored");

  a_reset_zero: assert property (
    $rose(rst_n) |-> regfile_out == '0 && !pulse_out)
    else $error("registers not zero after reset");

  // ----------------------------------------------------------------
  // Entry checks: decode held against the offsets, not the decoder
  // ----------------------------------------------------------------
  sequence s_write_at_eight;
    dbg_req_in.wr && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_EIGHT;
  endsequence

  sequence s_write_at_nine;
    dbg_req_in.wr && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_NINE;
  endsequence

  sequence s_write_at_ten;
    dbg_req_in.wr && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_TEN;
  endsequence

  sequence s_write_at_eleven;
    dbg_req_in.wr && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_ELEVEN;
  endsequence

  sequence s_read_at_eight;
    dbg_req_in.rd && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_EIGHT;
  endsequence

  sequence s_read_at_nine;
    dbg_req_in.rd && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_NINE;
  endsequence

  sequence s_read_at_ten;
    dbg_req_in.rd && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_TEN;
  endsequence

  sequence s_read_at_eleven;
    dbg_req_in.rd && dbg_req_in.addr == dbg_window_pkg::OFS_WORD_ELEVEN;
  endsequence

  sequence s_read_unmapped;
    dbg_req_in.rd &&
      dbg_req_in.addr != dbg_window_pkg::OFS_WORD_EIGHT &&
      dbg_req_in.addr != dbg_window_pkg::OFS_WORD_NINE &&
      dbg_req_in.addr != dbg_window_pkg::OFS_WORD_TEN &&
      dbg_req_in.addr != dbg_window_pkg::OFS_WORD_ELEVEN;
  endsequence

  a_write_word_eight: assert property (
    s_write_at_eight |=> regfile_out.eight == $past(dbg_req_in.wdata))
    else $error("write at first offset missed word eight");

  a_write_word_nine: assert property (
    s_write_at_nine |=> regfile_out.nine == $past(dbg_req_in.wdata))
    else $error("write at second offset missed word nine");

  a_write_word_ten: assert property (
    s_write_at_ten |=> regfile_out.ten == $past(dbg_req_in.wdata))
    else $error("write at third offset missed word ten");

  a_write_word_eleven: assert property (
    s_write_at_eleven |=> regfile_out.eleven == $past(dbg_req_in.wdata))
    else $error("write at fourth offset missed word eleven");

  a_read_word_eight: assert property (
    s_read_at_eight |=> rdata_out == $past(regfile_out.eight))
    else $error("read at first offset did not return word eight");

  a_read_word_nine: assert property (
    s_read_at_nine |=> rdata_out == $past(regfile_out.nine))
    else $error("read at second offset did not return word nine");

  a_read_word_ten: assert property (
    s_read_at_ten |=> rdata_out == $past(regfile_out.ten))
    else $error("read at third offset did not return word ten");

  a_read_word_eleven: assert property (
    s_read_at_eleven |=> rdata_out == $past(regfile_out.eleven))
    else $error("read at fourth offset did not return word eleven");

  a_unmapped_read_zero: assert property (
    s_read_unmapped |=> rdata_out == dbg_window_pkg::READ_IDLE)
    else $error("unmapped read returned data");

  a_read_after_write: assert property (
    s_write_at_eleven ##1 s_read_at_eleven |=>
      rdata_out == $past(dbg_req_in.wdata, 2))
    else $error("read after write missed the new word");

  a_rdata_one_cycle: assert property (
    dbg_rd_hit ##1 !dbg_req_in.rd |=>
      rdata_out == dbg_window_pkg::READ_IDLE)
    else $error("read data stood longer than one cycle");

  // ----------------------------------------------------------------
  // State and pulse checks
  // ----------------------------------------------------------------
  a_words_hold_idle: assert property (
    !dbg_wr_hit && !core_wr_in.en |=> regfile_out == $past(regfile_out))
    else $error("register word changed without a write");

  a_read_no_effect: assert property (
    dbg_req_in.rd && !dbg_req_in.wr && !core_wr_in.en |=>
      regfile_out == $past(regfile_out) && !pulse_out)
    else $error("read changed state or pulsed");

  a_core_pin_pulse: assert property (
    core_wr_in.en && !dbg_wr_hit && core_wr_in.idx == PULSE_ENTRY |=>
      pulse_out && output_pin_register_out == $past(core_wr_in.data))
    else $error("core pin write gave no pulse");

  a_other_write_quiet: assert property (
    dbg_wr_hit && hit_idx != PULSE_ENTRY && !core_wr_in.en |=> !pulse_out)
    else $error("pulse after a write to another word");

  a_core_other_quiet: assert property (
    core_wr_in.en && core_wr_in.idx != PULSE_ENTRY && !dbg_wr_hit |=>
      !pulse_out)
    else $error("pulse after a core write to another word");

  a_pulse_one_cycle: assert property (
    pulse_out && !dbg_wr_hit && !core_wr_in.en |=> !pulse_out)
    else $error("pulse stood longer than one cycle");

  a_clash_core_lost: assert property (
    dbg_wr_hit && core_wr_in.en && core_wr_in.idx != hit_idx |=>
      words[$past(core_wr_in.idx)] == $past(words[core_wr_in.idx]))
    else $error("core write stored despite a debug write");

  a_core_then_read: assert property (
    core_wr_in.en && !dbg_wr_hit ##1
      dbg_rd_hit && hit_idx == $past(core_wr_in.idx) |=>
      rdata_out == $past(core_wr_in.data, 2))
    else $error("debug read missed a core write");

  a_reset_read_zero: assert property (
    $rose(rst_n) |-> rdata_out == dbg_window_pkg::READ_IDLE &&
      output_pin_register_out == dbg_window_pkg::WORD_RESET)
    else $error("read data or pin word not zero after reset");

endmodule // core_debug_regfile_window

// ===== tb/core_model.sv
// Behavioural core that writes its own register words
`timescale 1ns/1ps
module core_model (
  input wire logic mclk_in,
  input wire logic halted_in,
  output dbg_window_pkg::core_wr_t core_wr_out
);
  initial core_wr_out = '0;
  // Writes only while running, so debug traffic never meets core traffic
  task automatic run_write(input logic [1:0] idx, input logic [31:0] d);
    @(posedge mclk_in);
    if (!halted_in) begin
      core_wr_out <= '{en: 1'b1, idx: idx, data: d};
      @(posedge mclk_in);
      core_wr_out <= '0;
    end
  endtask
endmodule // core_model

// ===== tb/tb_top.sv
// Self-checking bench for the debug register-file window
`timescale 1ns/1ps
module tb_top;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic halted = 1'b1;
  logic pulse;
  logic [31:0] rdata, pin_word, got;
  dbg_window_pkg::dbg_req_t dbg_req = '0;
  dbg_window_pkg::core_wr_t core_wr;
  dbg_window_pkg::regfile_view_t regfile;
  int n_errors = 0;
  int total_checks = 0;
  always #10 mclk_in = ~mclk_in;
  core_debug_regfile_window i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .dbg_req_in(dbg_req), .core_wr_in(core_wr), .rdata_out(rdata),
    .regfile_out(regfile), .output_pin_register_out(pin_word),
    .pulse_out(pulse));
  core_model i_core (.mclk_in(mclk_in), .halted_in(halted),
    .core_wr_out(core_wr));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] pat(int i);
    return {8'hc3, 8'(i), 16'h5a0f};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    dbg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_in);
    dbg_req <= '0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    dbg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk_in);
    dbg_req <= '0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 4; i++) begin
      bus_rd(8'(32 + 4 * i), got);
      chk(got, 32'h0000_0000, "reset value");
    end
    chk(pin_word, 32'h0000_0000, "pin word after reset");
    $display("test reset values done");
    for (int i = 0; i < 4; i++) bus_wr(8'(32 + 4 * i), pat(i));
    for (int i = 0; i < 4; i++) begin
      bus_rd(8'(32 + 4 * i), got);
      chk(got, pat(i), "read back");
      chk(regfile[32 * i +: 32], pat(i), "core view");
    end
    $display("test read write done");
    bus_wr(8'h2c, 32'h8000_0001);
    chk({31'h0, pulse}, 32'h1, "no pulse on pin write");
    chk(pin_word, 32'h8000_0001, "pin word");
    @(posedge mclk_in);
    #1 chk({31'h0, pulse}, 32'h0, "pulse too long");
    bus_wr(8'h20, 32'h0000_0000);
    chk({31'h0, pulse}, 32'h0, "pulse on other word");
    $display("test pulse done");
    bus_wr(8'h30, 32'hffff_ffff);
    bus_rd(8'h30, got);
    chk(got, 32'h0000_0000, "unmapped read");
    bus_rd(8'h24, got);
    chk(got, pat(1), "unmapped write leaked");
    $display("test unmapped done");
    halted = 1'b0;
    i_core.run_write(2'h3, 32'h0000_00f0);
    #1 chk({31'h0, pulse}, 32'h1, "core write pulse");
    halted = 1'b1;
    bus_rd(8'h2c, got);
    chk(got, 32'h0000_00f0, "core write unseen");
    chk(pin_word, 32'h0000_00f0, "core pin word");
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk(regfile[32 * i +: 32], 32'h0000_0000, "mid-run reset");
    end
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    bus_rd(8'h2c, got);
    chk(got, 32'h0000_0000, "read after mid-run reset");
    chk({31'h0, pulse}, 32'h0, "pulse after mid-run reset");
    $display("test core link done");
    tally_and_finish();
  end
endmodule // tb_top
